//--- verilog/pwm_auto_shutdown_control.v
// PWM output stage with auto-shutdown, restart and period timer.
// Assumes a plain register port: one-cycle strobes, read data in the next cycle.
`timescale 1ns/100ps
`include "pwm_shutdown_consts.vh"
module pwm_auto_shutdown_control (
  input  wire       mclk,
  input  wire       rst,
  input  wire       clk_run,
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_stb,
  input  wire       rd_stb,
  output reg  [7:0] rdata,
  input  wire       fault_input_n,
  input  wire       comparator_1,
  input  wire       comparator_2,
  output wire       pwm_out_a,
  output wire       pwm_out_a_oe_n,
  output wire       pwm_out_b,
  output wire       pwm_out_b_oe_n,
  output wire       pwm_out_c,
  output wire       pwm_out_c_oe_n,
  output wire       pwm_out_d,
  output wire       pwm_out_d_oe_n,
  output wire       period_timer_flag
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0] pwm_shutdown_control_r;
  reg  [7:0] dead_band_delay_register_r;
  reg  [7:0] pwm_mode_control_register_r;
  reg  [7:0] period_limit_register_r;
  reg  [7:0] duty_r;
  reg  [7:0] period_timer_r;
  reg        period_timer_flag_r;
  reg  [1:0] out_state_r;
  reg  [1:0] out_state_nxt;
  reg        fault_seen_r;
  reg        pwm_raw_r;
  reg  [7:0] sd_nxt;

  wire       fault_n_s;
  wire       cmp1_s;
  wire       cmp2_s;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pin_sync3 u_sync_fault (
    .mclk    (mclk),
    .rst     (rst),
    .rst_val (1'b1),
    .pin     (fault_input_n),
    .level_r (fault_n_s)
  );
  pin_sync3 u_sync_cmp1 (
    .mclk    (mclk),
    .rst     (rst),
    .rst_val (1'b0),
    .pin     (comparator_1),
    .level_r (cmp1_s)
  );
  pin_sync3 u_sync_cmp2 (
    .mclk    (mclk),
    .rst     (rst),
    .rst_val (1'b0),
    .pin     (comparator_2),
    .level_r (cmp2_s)
  );

  // ----------------------------------------------------------------
  // Shutdown condition
  // ----------------------------------------------------------------
  wire [2:0] src_sel = pwm_shutdown_control_r[`SD_SRC_HI:`SD_SRC_LO];
  wire       fault_raw = ~fault_input_n & src_sel[`SRC_FAULT_BIT];
  wire       cmp_raw = (comparator_1 & src_sel[`SRC_CMP1_BIT]) |
                       (comparator_2 & src_sel[`SRC_CMP2_BIT]);
  wire       cond_sync = (~fault_n_s & src_sel[`SRC_FAULT_BIT]) |
                         (cmp1_s & src_sel[`SRC_CMP1_BIT]) |
                         (cmp2_s & src_sel[`SRC_CMP2_BIT]);
  wire       restart_en = dead_band_delay_register_r[`RESTART_EN_BIT];
  wire       sd_flag = pwm_shutdown_control_r[`SD_FLAG_BIT];
  wire       wr_sd = wr_stb && (addr == `ADDR_SHUTDOWN_CTRL);

  // Pin path bypasses the clock so the outputs go safe at once
  wire       force_async = fault_raw | cmp_raw;

  // ----------------------------------------------------------------
  // Shutdown control register
  // ----------------------------------------------------------------
  always @* begin
    sd_nxt = pwm_shutdown_control_r;
    if (wr_sd) begin
      sd_nxt[`SD_SRC_HI:0] = wdata[`SD_SRC_HI:0];
      if (!cond_sync) begin
        sd_nxt[`SD_FLAG_BIT] = wdata[`SD_FLAG_BIT];
      end
    end
    if (cond_sync) begin
      sd_nxt[`SD_FLAG_BIT] = 1'b1;
    end else if (restart_en && fault_seen_r && !wr_sd) begin
      sd_nxt[`SD_FLAG_BIT] = 1'b0;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      pwm_shutdown_control_r <= `RESET_BYTE;
      fault_seen_r           <= 1'b0;
    end else if (clk_run) begin
      pwm_shutdown_control_r <= sd_nxt;
      // Auto clear only for flags set by a real condition, not by software force
      if (cond_sync) begin
        fault_seen_r <= 1'b1;
      end else if (!sd_nxt[`SD_FLAG_BIT]) begin
        fault_seen_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Other registers and read port
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      dead_band_delay_register_r  <= `RESET_BYTE;
      pwm_mode_control_register_r <= `RESET_BYTE;
      period_limit_register_r     <= `RESET_PERIOD;
      duty_r                      <= `RESET_BYTE;
      rdata                       <= `RESET_BYTE;
    end else begin
      if (wr_stb) begin
        case (addr)
          `ADDR_DEAD_BAND:    dead_band_delay_register_r  <= wdata;
          `ADDR_MODE_CTRL:    pwm_mode_control_register_r <= wdata;
          `ADDR_PERIOD_LIMIT: period_limit_register_r     <= wdata;
          `ADDR_DUTY:         duty_r                      <= wdata;
          default:            ;
        endcase
      end
      rdata <= `RESET_BYTE;
      if (rd_stb) begin
        case (addr)
          `ADDR_SHUTDOWN_CTRL: rdata <= pwm_shutdown_control_r;
          `ADDR_DEAD_BAND:     rdata <= dead_band_delay_register_r;
          `ADDR_MODE_CTRL:     rdata <= pwm_mode_control_register_r;
          `ADDR_PERIOD_LIMIT:  rdata <= period_limit_register_r;
          `ADDR_DUTY:          rdata <= duty_r;
          `ADDR_STATUS:        rdata <= {6'h00, cond_sync, period_timer_flag_r};
          default:             rdata <= `RESET_BYTE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Period timer
  // ----------------------------------------------------------------
  wire period_end = (period_timer_r == period_limit_register_r);
  wire clr_tflag = wr_stb && (addr == `ADDR_STATUS) && !wdata[`STAT_TIMER_FLAG];

  always @(posedge mclk) begin
    if (rst) begin
      period_timer_r      <= `RESET_BYTE;
      period_timer_flag_r <= 1'b0;
      pwm_raw_r           <= 1'b0;
    end else begin
      if (clk_run) begin
        if (period_end) begin
          period_timer_r <= `RESET_BYTE;
        end else begin
          period_timer_r <= period_timer_r + 8'h01;
        end
        pwm_raw_r <= period_end ? (duty_r != `RESET_BYTE) :
                     ((period_timer_r + 8'h01) < duty_r);
      end
      // Set wins over a clearing write in the same cycle
      if (clk_run && period_end) begin
        period_timer_flag_r <= 1'b1;
      end else if (clr_tflag) begin
        period_timer_flag_r <= 1'b0;
      end
    end
  end
  assign period_timer_flag = period_timer_flag_r;

  // ----------------------------------------------------------------
  // Output hold state
  // ----------------------------------------------------------------
  // A flag that drops mid-period must not release the pins by itself:
  // the waveform only comes back on a period boundary
  localparam ST_RUN  = 2'h0;
  localparam ST_SHUT = 2'h1;
  localparam ST_WAIT = 2'h2;

  wire flag_nxt = sd_nxt[`SD_FLAG_BIT];

  always @* begin
    out_state_nxt = out_state_r;
    case (out_state_r)
      ST_RUN: begin
        if (flag_nxt) begin
          out_state_nxt = ST_SHUT;
        end
      end
      ST_SHUT: begin
        if (!flag_nxt) begin
          out_state_nxt = period_end ? ST_RUN : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (flag_nxt) begin
          out_state_nxt = ST_SHUT;
        end else if (period_end) begin
          out_state_nxt = ST_RUN;
        end
      end
      default: out_state_nxt = ST_RUN;
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      out_state_r <= ST_RUN;
    end else if (clk_run) begin
      out_state_r <= out_state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  wire shut = (out_state_r != ST_RUN) | sd_flag | force_async;
  wire [1:0] lvl_ac = pwm_shutdown_control_r[`SD_AC_HI:`SD_AC_LO];
  wire [1:0] lvl_bd = pwm_shutdown_control_r[`SD_BD_HI:`SD_BD_LO];
  wire run_ac = pwm_raw_r ^ pwm_mode_control_register_r[`POL_AC_BIT];
  wire run_bd = ~pwm_raw_r ^ pwm_mode_control_register_r[`POL_BD_BIT];

  assign pwm_out_a      = shut ? (lvl_ac == `LVL_HIGH) : run_ac;
  assign pwm_out_c      = pwm_out_a;
  assign pwm_out_a_oe_n = shut & lvl_ac[1];
  assign pwm_out_c_oe_n = pwm_out_a_oe_n;
  assign pwm_out_b      = shut ? (lvl_bd == `LVL_HIGH) : run_bd;
  assign pwm_out_d      = pwm_out_b;
  assign pwm_out_b_oe_n = shut & lvl_bd[1];
  assign pwm_out_d_oe_n = pwm_out_b_oe_n;

endmodule // pwm_auto_shutdown_control

//--- verilog/pwm_shutdown_consts.vh
// Constants for the PWM auto-shutdown and restart block.
// Assumes a plain register port with one-cycle strobes and read data one cycle later.
`ifndef PWM_SHUTDOWN_CONSTS_VH
`define PWM_SHUTDOWN_CONSTS_VH

`define ADDR_SHUTDOWN_CTRL   4'h0
`define ADDR_DEAD_BAND       4'h1
`define ADDR_MODE_CTRL       4'h2
`define ADDR_PERIOD_LIMIT    4'h3
`define ADDR_DUTY            4'h4
`define ADDR_STATUS          4'h5

`define SD_FLAG_BIT          7
`define SD_SRC_HI            6
`define SD_SRC_LO            4
`define SD_AC_HI             3
`define SD_AC_LO             2
`define SD_BD_HI             1
`define SD_BD_LO             0
`define RESTART_EN_BIT       7
`define POL_AC_BIT           1
`define POL_BD_BIT           0

`define SRC_CMP1_BIT         0
`define SRC_CMP2_BIT         1
`define SRC_FAULT_BIT        2

`define LVL_LOW              2'h0
`define LVL_HIGH             2'h1

`define RESET_BYTE           8'h00
`define RESET_PERIOD         8'hff
`define STAT_TIMER_FLAG      0
`define STAT_CONDITION       1

`endif

//--- verilog/pin_sync3.v
// Three-stage synchroniser for asynchronous pins.
// Assumes one clock; the output changes once stages two and three agree.
`timescale 1ns/100ps
module pin_sync3 (
  input  wire mclk,
  input  wire rst,
  input  wire rst_val,
  input  wire pin,
  output reg  level_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // All stages start at the pin's idle level so no false edge follows reset
  always @(posedge mclk) begin
    if (rst) begin
      s1_r    <= rst_val;
      s2_r    <= rst_val;
      s3_r    <= rst_val;
      level_r <= rst_val;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
endmodule // pin_sync3

//--- test/bridge_model.sv
// Far-side model: current-sense comparators, fault line and bridge pads.
// Assumes the bench commands each trip; released pads sit on pull-downs.
`timescale 1ns/100ps
module bridge_model (
  input  wire [2:0] trip_cmd,
  input  wire [3:0] out,
  input  wire [3:0] oe_n,
  output wire       fault_input_n,
  output wire       comparator_1,
  output wire       comparator_2,
  output wire [3:0] pad
);
  assign comparator_1  = trip_cmd[0];
  assign comparator_2  = trip_cmd[1];
  assign fault_input_n = ~trip_cmd[2];
  // Pull-downs keep the switches off while a pin floats
  assign pad = out & ~oe_n;
endmodule // bridge_model

//--- test/pwm_shutdown_asserts.sv
// Port checker for the PWM auto-shutdown block.
// Bound to the design top; shadows the control byte from bus writes.
`timescale 1ns/100ps
module pwm_shutdown_asserts (
  input wire       mclk,
  input wire       rst,
  input wire       clk_run,
  input wire       wr_stb,
  input wire       rd_stb,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire [7:0] rdata,
  input wire       fault_input_n,
  input wire       comparator_1,
  input wire       comparator_2,
  input wire       period_timer_flag,
  input wire       pwm_out_a,
  input wire       pwm_out_a_oe_n,
  input wire       pwm_out_b,
  input wire       pwm_out_b_oe_n,
  input wire       pwm_out_c,
  input wire       pwm_out_c_oe_n,
  input wire       pwm_out_d,
  input wire       pwm_out_d_oe_n
);
  reg  [7:0] cfg_r;
  reg  [2:0] trip_cnt_r;
  wire       trip = (cfg_r[4] & comparator_1) | (cfg_r[5] & comparator_2)
                    | (cfg_r[6] & ~fault_input_n);
  wire [3:0] ac_pins = {pwm_out_a_oe_n, pwm_out_c_oe_n, pwm_out_a, pwm_out_c};
  wire [3:0] bd_pins = {pwm_out_b_oe_n, pwm_out_d_oe_n, pwm_out_b, pwm_out_d};
  // ----------------------------------------
  // Shadow setup and settled-trip counter
  // ----------------------------------------
  always @(posedge mclk) begin
    if (rst)
      cfg_r <= 8'h00;
    else if (wr_stb && addr == 4'h0)
      cfg_r <= wdata;
  end
  // Seven cycles covers the pin synchroniser before the flag must show
  always @(posedge mclk) begin
    if (rst || !trip || !clk_run)
      trip_cnt_r <= 3'h0;
    else if (trip_cnt_r != 3'h7)
      trip_cnt_r <= trip_cnt_r + 3'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_ac_tri; trip && cfg_r[3] |-> ac_pins[3:2] == 2'b11; endproperty
  a_ac_tri: assert property (p_ac_tri) else $error("a/c not released");
  property p_ac_lvl; trip && !cfg_r[3] |-> ac_pins == {2'b00, {2{cfg_r[2]}}}; endproperty
  a_ac_lvl: assert property (p_ac_lvl) else $error("a/c level wrong");
  property p_bd_tri; trip && cfg_r[1] |-> bd_pins[3:2] == 2'b11; endproperty
  a_bd_tri: assert property (p_bd_tri) else $error("b/d not released");
  property p_bd_lvl; trip && !cfg_r[1] |-> bd_pins == {2'b00, {2{cfg_r[0]}}}; endproperty
  a_bd_lvl: assert property (p_bd_lvl) else $error("b/d level wrong");
  property p_flag_rd; rd_stb && addr == 4'h0 && trip_cnt_r == 3'h7 |=> rdata[7]; endproperty
  a_flag_rd: assert property (p_flag_rd) else $error("flag clear in trip");
  property p_rd_idle; !$past(rd_stb) |-> rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_tf_hold; period_timer_flag && !(wr_stb && addr == 4'h5) |=> period_timer_flag;
  endproperty
  a_tf_hold: assert property (p_tf_hold) else $error("timer flag dropped");
  property p_sleep; !clk_run && !period_timer_flag |=> !period_timer_flag; endproperty
  a_sleep: assert property (p_sleep) else $error("timer ran in sleep");
endmodule // pwm_shutdown_asserts
bind pwm_auto_shutdown_control pwm_shutdown_asserts i_pwm_shutdown_asserts (.*);

//--- test/pwm_auto_shutdown_control_test.sv
// Self-checking bench for the PWM auto-shutdown block.
// Drives the register port at the rising edge; far-side pins come from the model.
`timescale 1ns/100ps
module pwm_auto_shutdown_control_test;
  reg        mclk = 1'b0, rst = 1'b1, clk_run = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
  reg  [3:0] addr = 4'h0;
  reg  [7:0] wdata = 8'h00;
  reg  [2:0] trip_cmd = 3'h0;
  wire [7:0] rdata;
  wire [3:0] pad;
  wire       fault_input_n, comparator_1, comparator_2, period_timer_flag;
  wire       pwm_out_a, pwm_out_a_oe_n, pwm_out_b, pwm_out_b_oe_n;
  wire       pwm_out_c, pwm_out_c_oe_n, pwm_out_d, pwm_out_d_oe_n;
  integer    bad_count = 0, tests_run = 0, i, k, n;

  pwm_auto_shutdown_control i_pwm_auto_shutdown_control (.*);
  bridge_model i_bridge_model (.trip_cmd(trip_cmd), .pad(pad),
    .out({pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d}),
    .oe_n({pwm_out_a_oe_n, pwm_out_b_oe_n, pwm_out_c_oe_n, pwm_out_d_oe_n}),
    .fault_input_n(fault_input_n), .comparator_1(comparator_1), .comparator_2(comparator_2));

  initial begin
    forever #4 mclk = ~mclk;
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task chk(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [7:0] exp);
    begin
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 chk(rdata, exp);
    end
  endtask
  // Pads as {enables_n a,b,c,d, levels a,b,c,d}
  task pins(input [7:0] exp);
    begin
      #1 chk({pwm_out_a_oe_n, pwm_out_b_oe_n, pwm_out_c_oe_n, pwm_out_d_oe_n, pad}, exp);
    end
  endtask
  // Clears the timer flag, then waits for the next period boundary
  task wait_tf;
    begin
      wr(4'h5, 8'h00);
      n = 0;
      do begin
        @(posedge mclk);
        #1 n = n + 1;
      end while (period_timer_flag !== 1'b1 && n < 300);
      chk({7'h00, period_timer_flag}, 8'h01);
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h3, 8'hff);
    rd(4'h9, 8'h00);
    wr(4'h3, 8'h07);
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h0, 8'hc4);
    pins(8'h0a);
    wait_tf;
    wr(4'h0, 8'h44);
    pins(8'h0a);
    wait_tf;
    repeat (2) @(posedge mclk);
    pins(8'h05);
    @(posedge mclk);
    trip_cmd <= 3'b100;
    pins(8'h0a);
    repeat (6) @(posedge mclk);
    wr(4'h0, 8'h44);
    rd(4'h0, 8'hc4);
    rd(4'h5, 8'h03);
    @(posedge mclk);
    trip_cmd <= 3'b000;
    repeat (8) @(posedge mclk);
    rd(4'h0, 8'hc4);
    wr(4'h0, 8'h44);
    rd(4'h0, 8'h44);
    wr(4'h1, 8'h80);
    rd(4'h1, 8'h80);
    for (i = 0; i < 8; i = i + 1)
      for (k = 0; k < 3; k = k + 1) begin
        wr(4'h0, {1'b0, i[2:0], 4'ha});
        trip_cmd <= 3'b001 << k;
        repeat (7) @(posedge mclk);
        rd(4'h0, {i[k], i[2:0], 4'ha});
        if (i[k]) pins(8'hf0);
        @(posedge mclk);
        trip_cmd <= 3'b000;
        repeat (7) @(posedge mclk);
        rd(4'h0, {1'b0, i[2:0], 4'ha});
      end
    wr(4'h0, 8'h80);
    repeat (8) @(posedge mclk);
    rd(4'h0, 8'h80);
    pins(8'h00);
    wr(4'h0, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      wr(4'h2, i[7:0]);
      wait_tf;
      repeat (2) @(posedge mclk);
      pins({4'h0, i[1], ~i[0], i[1], ~i[0]});
    end
    rd(4'h2, 8'h03);
    wait_tf;
    wr(4'h5, 8'h00);
    @(posedge mclk);
    clk_run <= 1'b0;
    repeat (30) @(posedge mclk);
    chk({7'h00, period_timer_flag}, 8'h00);
    pins(8'h0a);
    @(posedge mclk);
    clk_run <= 1'b1;
    wait_tf;
    wr(4'h4, 8'h03);
    rd(4'h4, 8'h03);
    give_verdict;
  end

  initial begin
    #100000;
    bad_count = bad_count + 1;
    give_verdict;
  end
endmodule // pwm_auto_shutdown_control_test
